//--- logic/dmm_map.vh
// Constants for the data memory decoder: SFR addresses, fields, reset values.
// Included by the decoder modules; definitions only.
`ifndef DMM_MAP_VH
`define DMM_MAP_VH

`define DMM_ADDR_XRAM_PAGE     8'hE7
`define DMM_ADDR_PAGE_SELECT   8'hA7
`define DMM_ADDR_STACK_CTRL    8'hCF
`define DMM_ADDR_STACK_READ    8'hD7
`define DMM_ADDR_STACK_POINTER 8'h81
`define DMM_ADDR_PSW           8'hD0

`define DMM_XRAM_PAGE_MSB      3
`define DMM_XRAM_PAGE_RESET    4'h0
`define DMM_SP_RESET           8'h07
`define DMM_PAGE_RESET         8'h00
`define DMM_CTRL_EN_BIT        0
`define DMM_CTRL_IDX_LSB       4
`define DMM_CTRL_IDX_MSB       6
`define DMM_CTRL_RESET         8'h01
`define DMM_PSW_BANK_LSB       3
`define DMM_PSW_BANK_MSB       4
`define DMM_BITAREA_BASE       8'h20
`define DMM_SFR_BASE           8'h80
`define DMM_STACK_DEPTH        5

`endif

//--- logic/dmm_stack_slot.v
// One slot of the peripheral page stack.
// Shifts down on interrupt entry, up on return; same clock as the core.
`timescale 1ns/100ps
`include "dmm_map.vh"

module dmm_stack_slot
(
    clock,
    resetn,
    push,
    pop,
    from_above,
    from_below,
    value
);
    input  wire       clock;
    input  wire       resetn;
    input  wire       push;
    input  wire       pop;
    input  wire [7:0] from_above;
    input  wire [7:0] from_below;
    output reg  [7:0] value;

    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            value <= `DMM_PAGE_RESET;
        else if (push)
            value <= from_above;
        else if (pop)
            value <= from_below;
    end
endmodule // dmm_stack_slot

//--- logic/dmm_ram.v
// 256-byte internal RAM, one write and one read port.
// Contents are not reset, as RAM survives a reset.
`timescale 1ns/100ps

module dmm_ram
(
    clock,
    wr_en,
    wr_addr,
    wr_data,
    rd_addr,
    rd_data
);
    input  wire       clock;
    input  wire       wr_en;
    input  wire [7:0] wr_addr;
    input  wire [7:0] wr_data;
    input  wire [7:0] rd_addr;
    output wire [7:0] rd_data;

    reg [7:0] mem [0:255];

    // Read is combinational so the decoder registers the answer in one cycle
    assign rd_data = mem[rd_addr];

    always @(posedge clock)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end
endmodule // dmm_ram

//--- logic/dmm_decoder.v
// Data memory decoder: internal RAM, banks, bit area, stack pointer,
// XRAM page, SFR paging and the five-deep page stack.
// Assumes a core on the same clock issuing one access per cycle.
`timescale 1ns/100ps
`include "dmm_map.vh"

module dmm_decoder
#(
    parameter CODE_ADDR_WIDTH = 16
)
(
    clock,
    resetn,
    acc_valid,
    acc_write,
    acc_indirect,
    acc_bit,
    acc_ptr_sel,
    acc_addr,
    acc_wdata,
    acc_bit_wdata,
    push_req,
    pop_req,
    push_data,
    irq_enter,
    irq_exit,
    irq_page,
    xmove_valid,
    xmove_write,
    xmove_wide,
    xmove_flash_mode,
    xmove_addr,
    xmove_wdata,
    code_move_addr,
    code_fetch_addr,
    rd_data,
    rd_bit,
    rd_valid,
    stack_pointer,
    periph_page_select,
    sfr_strobe,
    sfr_write,
    sfr_addr,
    sfr_wdata,
    sfr_core,
    xram_addr,
    xram_write,
    xram_valid,
    xram_wdata,
    flash_write,
    code_addr
);
    input  wire                       clock;
    input  wire                       resetn;
    input  wire                       acc_valid;
    input  wire                       acc_write;
    input  wire                       acc_indirect;
    input  wire                       acc_bit;
    input  wire                       acc_ptr_sel;
    input  wire [7:0]                 acc_addr;
    input  wire [7:0]                 acc_wdata;
    input  wire                       acc_bit_wdata;
    input  wire                       push_req;
    input  wire                       pop_req;
    input  wire [7:0]                 push_data;
    input  wire                       irq_enter;
    input  wire                       irq_exit;
    input  wire [7:0]                 irq_page;
    input  wire                       xmove_valid;
    input  wire                       xmove_write;
    input  wire                       xmove_wide;
    input  wire                       xmove_flash_mode;
    input  wire [15:0]                xmove_addr;
    input  wire [7:0]                 xmove_wdata;
    input  wire [CODE_ADDR_WIDTH-1:0] code_move_addr;
    input  wire [CODE_ADDR_WIDTH-1:0] code_fetch_addr;
    output reg  [7:0]                 rd_data;
    output reg                        rd_bit;
    output reg                        rd_valid;
    output reg  [7:0]                 stack_pointer;
    output reg  [7:0]                 periph_page_select;
    output reg                        sfr_strobe;
    output reg                        sfr_write;
    output reg  [7:0]                 sfr_addr;
    output reg  [7:0]                 sfr_wdata;
    output reg                        sfr_core;
    output reg  [15:0]                xram_addr;
    output reg                        xram_write;
    output reg                        xram_valid;
    output reg  [7:0]                 xram_wdata;
    output reg                        flash_write;
    output reg  [CODE_ADDR_WIDTH-1:0] code_addr;

    reg  [3:0] xram_page_field;
    reg  [7:0] program_status_word;
    reg        auto_page_switch_enable;
    reg  [2:0] page_stack_index;
    reg  [7:0] idx_ptr0;
    reg  [7:0] idx_ptr1;
    reg        pend_ptr;
    reg        pend_bit;
    reg  [7:0] pend_addr;
    reg        pend_sfr;
    reg  [7:0] pend_data;
    reg  [7:0] next_sp;
    reg  [7:0] eff_addr;
    reg        is_sfr;
    reg  [7:0] byte_addr;
    reg  [2:0] bit_pos;
    reg        ram_wr;
    reg  [7:0] ram_wr_addr;
    reg  [7:0] ram_wr_data;
    reg  [7:0] sfr_rd;
    reg        core_hit;
    wire [7:0] ram_rd;
    wire [7:0] slot [0:`DMM_STACK_DEPTH];
    wire       auto_push;
    wire       auto_pop;
    wire [1:0] bank;

    assign bank      = program_status_word[`DMM_PSW_BANK_MSB:`DMM_PSW_BANK_LSB];
    assign auto_push = irq_enter & auto_page_switch_enable;
    assign auto_pop  = irq_exit & auto_page_switch_enable & ~irq_enter;

    // Lower slots shift as one chain; bottom falls off on overflow
    assign slot[0]                = periph_page_select;
    assign slot[`DMM_STACK_DEPTH] = `DMM_PAGE_RESET;
    genvar g;
    generate
        for (g = 1; g < `DMM_STACK_DEPTH; g = g + 1)
        begin : g_slot
            dmm_stack_slot u_slot
            (
                .clock      (clock),
                .resetn     (resetn),
                .push       (auto_push),
                .pop        (auto_pop),
                .from_above (slot[g-1]),
                .from_below (slot[g+1]),
                .value      (slot[g])
            );
        end
    endgenerate

    // Address formation
    always @*
    begin
        eff_addr  = acc_indirect ? (acc_ptr_sel ? idx_ptr1 : idx_ptr0) : acc_addr;
        is_sfr    = 1'b0;
        byte_addr = eff_addr;
        bit_pos   = 3'h0;
        if (acc_bit)
        begin
            bit_pos = acc_addr[2:0];
            if (acc_addr[7])
            begin
                byte_addr = {acc_addr[7:3], 3'h0};
                is_sfr    = 1'b1;
            end
            else
                byte_addr = `DMM_BITAREA_BASE + {4'h0, acc_addr[6:3]};
        end
        else if (!acc_indirect && eff_addr[7])
            is_sfr = 1'b1;
        // Indirect above 0x7F stays RAM (upper half)
        next_sp = stack_pointer + 8'h01;
    end

    // Core SFRs decode identically on every page
    always @*
    begin
        core_hit = 1'b1;
        case (byte_addr)
            `DMM_ADDR_XRAM_PAGE:     sfr_rd = {4'h0, xram_page_field};
            `DMM_ADDR_PAGE_SELECT:   sfr_rd = periph_page_select;
            `DMM_ADDR_STACK_POINTER: sfr_rd = stack_pointer;
            `DMM_ADDR_PSW:           sfr_rd = program_status_word;
            `DMM_ADDR_STACK_CTRL:    sfr_rd = {1'b0, page_stack_index, 3'h0, auto_page_switch_enable};
            `DMM_ADDR_STACK_READ:
                sfr_rd = (page_stack_index < `DMM_STACK_DEPTH) ? slot[page_stack_index] : 8'h00;
            default:
            begin
                sfr_rd   = 8'h00;
                core_hit = 1'b0; // Paged SFRs answered outside on the page
            end
        endcase
    end

    // RAM write source: push, byte write, or bit read-modify
    always @*
    begin
        ram_wr      = 1'b0;
        ram_wr_addr = byte_addr;
        ram_wr_data = acc_wdata;
        if (push_req)
        begin
            ram_wr      = 1'b1;
            ram_wr_addr = next_sp;
            ram_wr_data = push_data;
        end
        else if (pend_bit && !pend_sfr)
        begin
            ram_wr      = 1'b1;
            ram_wr_addr = pend_addr;
            ram_wr_data = pend_data;
        end
        else if (acc_valid && acc_write && !acc_bit && !is_sfr)
            ram_wr = 1'b1;
    end

    dmm_ram u_ram
    (
        .clock   (clock),
        .wr_en   (ram_wr),
        .wr_addr (ram_wr_addr),
        .wr_data (ram_wr_data),
        .rd_addr (pop_req ? stack_pointer : byte_addr),
        .rd_data (ram_rd)
    );

    // Register file and page logic
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            stack_pointer           <= `DMM_SP_RESET;
            xram_page_field         <= `DMM_XRAM_PAGE_RESET;
            program_status_word     <= 8'h00;
            periph_page_select      <= `DMM_PAGE_RESET;
            auto_page_switch_enable <= 1'b1;
            page_stack_index        <= 3'h0;
        end
        else
        begin
            if (push_req)
                stack_pointer <= next_sp;
            else if (pop_req)
                stack_pointer <= stack_pointer - 8'h01;
            if (acc_valid && acc_write && is_sfr && !acc_bit)
            begin
                case (byte_addr)
                    `DMM_ADDR_XRAM_PAGE:     xram_page_field <= acc_wdata[`DMM_XRAM_PAGE_MSB:0];
                    `DMM_ADDR_PAGE_SELECT:   periph_page_select <= acc_wdata;
                    `DMM_ADDR_STACK_POINTER: stack_pointer <= acc_wdata;
                    `DMM_ADDR_PSW:           program_status_word <= acc_wdata;
                    `DMM_ADDR_STACK_CTRL:
                    begin
                        auto_page_switch_enable <= acc_wdata[`DMM_CTRL_EN_BIT];
                        page_stack_index <= acc_wdata[`DMM_CTRL_IDX_MSB:`DMM_CTRL_IDX_LSB];
                    end
                    default: ;
                endcase
            end
            if (pend_bit && pend_sfr && pend_addr == `DMM_ADDR_PSW)
                program_status_word <= pend_data;
            // Hardware page change wins over a software write
            if (auto_push)
                periph_page_select <= irq_page;
            else if (auto_pop)
                periph_page_select <= slot[1];
        end
    end

    // Bit writes finish a cycle later; address and byte latched, bus moves on
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pend_bit  <= 1'b0;
            pend_addr <= 8'h00;
            pend_sfr  <= 1'b0;
            pend_data <= 8'h00;
            pend_ptr  <= 1'b0;
        end
        else
        begin
            pend_bit  <= acc_valid & acc_write & acc_bit & ~pend_bit;
            pend_addr <= byte_addr;
            pend_sfr  <= is_sfr;
            pend_data <= is_sfr ? sfr_rd : ram_rd;
            pend_data[bit_pos] <= acc_bit_wdata;
            pend_ptr  <= acc_valid & acc_indirect;
        end
    end

    // Pointer shadows from active bank, refreshed on write
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            idx_ptr0 <= 8'h00;
            idx_ptr1 <= 8'h00;
        end
        else if (ram_wr && ram_wr_addr == {3'h0, bank, 3'h0})
            idx_ptr0 <= ram_wr_data;
        else if (ram_wr && ram_wr_addr == {3'h0, bank, 3'h1})
            idx_ptr1 <= ram_wr_data;
    end

    // Outputs, all registered
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_data     <= 8'h00;
            rd_bit      <= 1'b0;
            rd_valid    <= 1'b0;
            sfr_strobe  <= 1'b0;
            sfr_write   <= 1'b0;
            sfr_addr    <= `DMM_SFR_BASE;
            sfr_wdata   <= 8'h00;
            sfr_core    <= 1'b0;
            xram_addr   <= 16'h0000;
            xram_write  <= 1'b0;
            xram_valid  <= 1'b0;
            xram_wdata  <= 8'h00;
            flash_write <= 1'b0;
            code_addr   <= {CODE_ADDR_WIDTH{1'b0}};
        end
        else
        begin
            rd_valid   <= acc_valid & ~acc_write;
            rd_data    <= is_sfr ? sfr_rd : ram_rd;
            rd_bit     <= is_sfr ? sfr_rd[bit_pos] : ram_rd[bit_pos];
            sfr_strobe <= acc_valid & is_sfr & ~core_hit;
            sfr_write  <= acc_valid & acc_write & is_sfr & ~core_hit;
            sfr_addr   <= byte_addr; // paged with periph_page_select
            sfr_wdata  <= acc_wdata;
            sfr_core   <= core_hit;
            xram_valid <= xmove_valid & ~(xmove_write & xmove_flash_mode);
            xram_write <= xmove_valid & xmove_write & ~xmove_flash_mode;
            flash_write <= xmove_valid & xmove_write & xmove_flash_mode;
            xram_wdata <= xmove_wdata;
            xram_addr  <= xmove_wide ? xmove_addr : {4'h0, xram_page_field, xmove_addr[7:0]};
            // Data space never feeds instruction fetch
            code_addr  <= (xmove_valid | pend_ptr) ? code_fetch_addr : code_move_addr;
        end
    end
endmodule // dmm_decoder

//--- verification/dmm_decoder_chk.sv
// Port checker for the data memory decoder.
// Bound to dmm_decoder; shadows page enable and XRAM page from SFR writes.
`timescale 1ns/100ps

module dmm_decoder_chk
(
    input  logic        clock, resetn, acc_valid, acc_write, acc_indirect, acc_bit,
    input  logic [7:0]  acc_addr, acc_wdata, irq_page, stack_pointer, periph_page_select, sfr_addr,
    input  logic        push_req, pop_req, irq_enter, irq_exit, xmove_valid, xmove_write,
    input  logic        xmove_wide, xmove_flash_mode, rd_valid, sfr_strobe, xram_valid, xram_write,
    input  logic        flash_write,
    input  logic [15:0] xmove_addr, xram_addr
);
    logic       auto_en;
    logic [3:0] xpage;
    logic       byte_wr;
    logic       core;
    assign byte_wr = acc_valid && acc_write && !acc_indirect && !acc_bit;
    assign core = acc_addr inside {8'hA7, 8'hE7, 8'hCF, 8'hD7, 8'h81, 8'hD0};
    // Internal state is invisible here, so follow it from the writes
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            auto_en <= 1'b1;
            xpage   <= 4'h0;
        end
        else if (byte_wr && acc_addr == 8'hCF)
            auto_en <= acc_wdata[0];
        else if (byte_wr && acc_addr == 8'hE7)
            xpage <= acc_wdata[3:0];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_enter_exit;
        irq_enter && auto_en && !acc_valid ##1 (!irq_enter && !irq_exit && !acc_valid)[*3] ##1 irq_exit;
    endsequence
    property p_sp_reset;
        $rose(resetn) |-> stack_pointer == 8'h07;
    endproperty
    a_sp_reset: assert property (p_sp_reset) else $error("stack pointer off after reset");
    property p_push;
        push_req && !pop_req |=> stack_pointer == $past(stack_pointer) + 8'h01;
    endproperty
    a_push: assert property (p_push) else $error("push did not advance pointer");
    property p_irq_page;
        irq_enter && auto_en |=> periph_page_select == $past(irq_page);
    endproperty
    a_irq_page: assert property (p_irq_page) else $error("entry page not taken");
    property p_irq_off;
        irq_enter && !auto_en && !acc_valid |=> $stable(periph_page_select);
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("page moved while switching off");
    property p_restore;
        s_enter_exit |=> periph_page_select == $past(periph_page_select, 5);
    endproperty
    a_restore: assert property (p_restore) else $error("page not restored on return");
    property p_narrow;
        xmove_valid && !xmove_wide && !xmove_flash_mode |=>
            xram_valid && xram_addr == {4'h0, $past(xpage), $past(xmove_addr[7:0])};
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow move address wrong");
    property p_flash;
        xmove_valid && xmove_write && xmove_flash_mode |=> flash_write && !xram_write;
    endproperty
    a_flash: assert property (p_flash) else $error("flash mode write went to XRAM");
    property p_sfr_direct;
        acc_valid && !acc_indirect && !acc_bit && acc_addr[7] && !core |=>
            sfr_strobe && sfr_addr == $past(acc_addr);
    endproperty
    a_sfr_direct: assert property (p_sfr_direct) else $error("direct high access missed SFR");
    property p_upper;
        acc_valid && acc_indirect |=> !sfr_strobe && rd_valid == !$past(acc_write);
    endproperty
    a_upper: assert property (p_upper) else $error("indirect access reached SFR");
    c_push: cover property (push_req);
    c_restore: cover property (s_enter_exit);
    c_flash: cover property (xmove_valid && xmove_flash_mode);
endmodule // dmm_decoder_chk

bind dmm_decoder dmm_decoder_chk u_chk
(
    .clock, .resetn, .acc_valid, .acc_write, .acc_indirect, .acc_bit, .acc_addr, .acc_wdata,
    .irq_page, .stack_pointer, .periph_page_select, .sfr_addr, .push_req, .pop_req, .irq_enter,
    .irq_exit, .xmove_valid, .xmove_write, .xmove_wide, .xmove_flash_mode, .rd_valid, .sfr_strobe,
    .xram_valid, .xram_write, .flash_write, .xmove_addr, .xram_addr
);

//--- verification/dmm_cpu_model.sv
// Core-side model: data, stack, interrupt and external move requests.
// Tasks are entered at a falling edge and drive on falling edges.
`timescale 1ns/100ps

module dmm_cpu_model
(
    input  logic        clock,
    output logic        acc_valid, acc_write, acc_indirect, acc_bit, acc_ptr_sel, acc_bit_wdata,
    output logic        push_req, pop_req, irq_enter, irq_exit,
    output logic        xmove_valid, xmove_write, xmove_wide, xmove_flash_mode,
    output logic [7:0]  acc_addr, acc_wdata, push_data, irq_page, xmove_wdata,
    output logic [15:0] xmove_addr
);
    initial
    begin
        {acc_valid, acc_write, acc_indirect, acc_bit, acc_ptr_sel, acc_bit_wdata} = 6'h00;
        {push_req, pop_req, irq_enter, irq_exit} = 4'h0;
        {xmove_valid, xmove_write, xmove_wide, xmove_flash_mode} = 4'h0;
        {acc_addr, acc_wdata, push_data, irq_page, xmove_wdata, xmove_addr} = 56'h0;
    end
    // Three idle cycles keep bit writes well apart
    task automatic gap;
        repeat (3) @(negedge clock);
    endtask
    task automatic acc(input logic w, i, b, p, input logic [7:0] a, d);
        {acc_write, acc_indirect, acc_bit, acc_ptr_sel} = {w, i, b, p};
        {acc_addr, acc_wdata, acc_bit_wdata} = {a, d, d[0]};
        acc_valid = 1'b1;
        @(negedge clock);
        acc_valid = 1'b0;
        // Released lines do not keep the old value
        {acc_addr, acc_wdata} = ~{a, d};
        gap();
    endtask
    task automatic stk(input logic pu, po, input logic [7:0] d);
        {push_req, pop_req, push_data} = {pu, po, d};
        @(negedge clock);
        {push_req, pop_req, push_data} = {2'b00, ~d};
        gap();
    endtask
    task automatic irq(input logic en, ex, input logic [7:0] pg);
        {irq_enter, irq_exit, irq_page} = {en, ex, pg};
        @(negedge clock);
        {irq_enter, irq_exit, irq_page} = {2'b00, ~pg};
        gap();
    endtask
    task automatic xm(input logic w, wd, f, input logic [15:0] a, input logic [7:0] d);
        {xmove_write, xmove_wide, xmove_flash_mode, xmove_addr, xmove_wdata} = {w, wd, f, a, d};
        xmove_valid = 1'b1;
        @(negedge clock);
        xmove_valid = 1'b0;
        {xmove_addr, xmove_wdata} = ~{a, d};
        gap();
    endtask
endmodule // dmm_cpu_model

//--- verification/dmm_decoder_bench.sv
// Self-checking bench for the data memory decoder.
// Core model drives requests; bench latches answers and compares them.
`timescale 1ns/100ps

module dmm_decoder_bench;
    typedef struct packed { logic [7:0] a; logic [7:0] d; } dmm_row_t;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        acc_valid, acc_write, acc_indirect, acc_bit, acc_ptr_sel, acc_bit_wdata;
    logic        push_req, pop_req, irq_enter, irq_exit, xmove_valid, xmove_write, xmove_wide;
    logic        xmove_flash_mode, rd_bit, rd_valid, sfr_strobe, sfr_write, xram_write, xram_valid;
    logic        flash_write, sfr_core;
    logic [7:0]  acc_addr, acc_wdata, push_data, irq_page, xmove_wdata, rd_data, stack_pointer;
    logic [7:0]  periph_page_select, sfr_addr, sfr_wdata, xram_wdata;
    logic [15:0] xmove_addr, xram_addr, code_addr;
    logic [9:0]  rdv;
    logic [24:0] sv;
    logic [25:0] xv;
    int          fail_count = 0;
    int          checks_done = 0;
    dmm_row_t    rows [5] = '{'{8'h00, 8'h11}, '{8'h1F, 8'h2E}, '{8'h2F, 8'h3D}, '{8'h55, 8'h4C},
                              '{8'h7F, 8'h5B}};

    always #2 clock = ~clock;

    dmm_cpu_model u_cpu
    (
        .clock, .acc_valid, .acc_write, .acc_indirect, .acc_bit, .acc_ptr_sel, .acc_bit_wdata,
        .push_req, .pop_req, .irq_enter, .irq_exit, .xmove_valid, .xmove_write, .xmove_wide,
        .xmove_flash_mode, .acc_addr, .acc_wdata, .push_data, .irq_page, .xmove_wdata, .xmove_addr
    );

    dmm_decoder u_dut
    (
        .clock, .resetn, .acc_valid, .acc_write, .acc_indirect, .acc_bit, .acc_ptr_sel, .acc_addr,
        .acc_wdata, .acc_bit_wdata, .push_req, .pop_req, .push_data, .irq_enter, .irq_exit, .irq_page,
        .xmove_valid, .xmove_write, .xmove_wide, .xmove_flash_mode, .xmove_addr, .xmove_wdata,
        .code_move_addr (16'h1234),
        .code_fetch_addr(16'h5678),
        .rd_data, .rd_bit, .rd_valid, .stack_pointer, .periph_page_select, .sfr_strobe, .sfr_write,
        .sfr_addr, .sfr_wdata, .sfr_core, .xram_addr, .xram_write, .xram_valid, .xram_wdata,
        .flash_write, .code_addr
    );

    // Answers stand one cycle, so catch them at the edge
    always @(posedge clock)
    begin
        if (rd_valid === 1'b1)
            rdv <= {sfr_core, rd_bit, rd_data};
        if (sfr_strobe === 1'b1)
            sv <= {sfr_write, periph_page_select, sfr_addr, sfr_wdata};
        if ((xram_valid | flash_write) === 1'b1)
            xv <= {xram_write, flash_write, xram_addr, xram_wdata};
    end

    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        u_cpu.acc(1'b1, 1'b0, 1'b0, 1'b0, a, d);
    endtask
    task automatic rd(input logic i, p, input logic [7:0] a, e, input string n);
        rdv = 'x;
        u_cpu.acc(1'b0, i, 1'b0, p, a, 8'h00);
        chk(n, e, rdv[7:0]);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        fail_count++;
        results();
    end

    initial
    begin
        repeat (12) @(negedge clock);
        resetn = 1'b1;
        chk("sp", 8'h07, stack_pointer);
        rd(0, 0, 8'hE7, 8'h00, "xpage");
        rd(0, 0, 8'hCF, 8'h01, "ctrl");
        foreach (rows[k])
            wr(rows[k].a, rows[k].d);
        foreach (rows[k])
            rd(0, 0, rows[k].a, rows[k].d, "ram");
        wr(8'h00, 8'h90);
        u_cpu.acc(1, 1, 0, 0, 8'h00, 8'h5A);
        sv = 'x;
        wr(8'h90, 8'hC6);
        chk("sfr90", {1'b1, 8'h00, 8'h90, 8'hC6}, sv);
        rd(1, 0, 8'h00, 8'h5A, "upper");
        wr(8'hD0, 8'h08);
        wr(8'h09, 8'h40);
        u_cpu.acc(1, 1, 0, 1, 8'h00, 8'h3C);
        rd(0, 0, 8'h40, 8'h3C, "bank");
        wr(8'hD0, 8'h00);
        wr(8'h22, 8'h00);
        u_cpu.acc(1, 0, 1, 0, 8'h13, 8'h01);
        rd(0, 0, 8'h22, 8'h08, "bitbyte");
        rdv = 'x;
        u_cpu.acc(0, 0, 1, 0, 8'h13, 8'h00);
        chk("bit", 1'b1, rdv[8]);
        u_cpu.stk(1, 0, 8'hC3);
        chk("push", 8'h08, stack_pointer);
        rd(0, 0, 8'h08, 8'hC3, "slot");
        u_cpu.stk(0, 1, 8'h00);
        chk("pop", 8'h07, stack_pointer);
        wr(8'hE7, 8'h05);
        rd(0, 0, 8'hE7, 8'h05, "xpage");
        xv = 'x;
        u_cpu.xm(1, 0, 0, 16'hAA34, 8'h6E);
        chk("narrow", {2'b10, 16'h0534, 8'h6E}, xv);
        u_cpu.xm(0, 1, 0, 16'hABCD, 8'h00);
        chk("wide", {2'b00, 16'hABCD}, xv[25:8]);
        u_cpu.xm(1, 1, 1, 16'h1200, 8'h55);
        chk("flash", 2'b01, xv[25:24]);
        chk("codeaddr", 16'h1234, code_addr);
        wr(8'hA7, 8'h10);
        rd(0, 0, 8'hA7, 8'h10, "pagerd");
        wr(8'h91, 8'h4D);
        chk("paged", {1'b1, 8'h10, 8'h91, 8'h4D}, sv);
        rd(0, 0, 8'hE7, 8'h05, "core");
        chk("corehit", 1'b1, rdv[9]);
        u_cpu.irq(1, 0, 8'h20);
        chk("enter", 8'h20, periph_page_select);
        u_cpu.irq(0, 1, 8'h00);
        chk("exit", 8'h10, periph_page_select);
        for (int k = 1; k <= 6; k++)
            u_cpu.irq(1, 0, k[7:0]);
        for (int k = 0; k <= 4; k++)
        begin
            wr(8'hCF, {1'b0, k[2:0], 4'h1});
            rd(0, 0, 8'hD7, 8'(6 - k), "stack");
        end
        for (int k = 5; k >= 2; k--)
        begin
            u_cpu.irq(0, 1, 8'h00);
            chk("return", k[7:0], periph_page_select);
        end
        wr(8'hCF, 8'h00);
        u_cpu.irq(1, 0, 8'h33);
        chk("noswitch", 8'h02, periph_page_select);
        u_cpu.stk(1, 0, 8'hA5);
        @(negedge clock);
        resetn = 1'b0;
        @(negedge clock);
        resetn = 1'b1;
        chk("sp2", 8'h07, stack_pointer);
        chk("page2", 8'h00, periph_page_select);
        rd(0, 0, 8'hCF, 8'h01, "ctrl2");
        rd(0, 0, 8'h55, 8'h4C, "keep");
        results();
    end
endmodule // dmm_decoder_bench
